/* File: rtl/pimoc_pkg.sv */
// Purpose: shared constants for the port interrupt mask / operation control bank
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   byte address of a register is four times its index
package pimoc_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 10;
    localparam int          DATA_W      = 32;
    localparam int          LB_W        = 8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_IRQ_STATUS = 8'h1b;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h1f;
    localparam logic [7:0]  IDX_OP_CTL     = 8'h20;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          MSK_ANEG      = 3;
    localparam int          MSK_PTP       = 2;
    localparam int          MSK_PHY       = 1;
    localparam int          MSK_ACL       = 0;
    localparam int          OPC_LOCAL_LB  = 7;
    localparam int          OPC_REMOTE_LB = 6;
    localparam int          OPC_TAIL      = 2;
    localparam int          OPC_QS_HI     = 1;
    localparam int          OPC_QS_LO     = 0;
    localparam logic [3:0]  MASK_RST      = 4'h0;
    localparam logic [1:0]  QS_RST        = 2'h0;
    localparam logic [1:0]  QS_ONE        = 2'h0;
    localparam logic [1:0]  QS_TWO        = 2'h1;
    localparam logic [1:0]  QS_FOUR       = 2'h2;
    localparam logic [1:0]  QS_RSVD       = 2'h3;
    localparam int          PORT_ANEG     = 7;

    // ------------------------------------------------------------
    // write channel states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_PART = 2'h1,
        WR_RESP = 2'h3
    } pimoc_wr_e;
endpackage

/* File: rtl/pimoc_irq_gate.sv */
// Purpose: gates the four port event levels by the enable mask into one interrupt
// Assumes: mask bit 0 enables, 1 disables
// Notes:   sources a port lacks are tied off by parameter
`timescale 1ns/1ps
module pimoc_irq_gate #(
    parameter int PORT_NUM = 1,
    parameter bit HAS_PHY  = 1'b1
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] sts,
    input  wire logic [3:0] mask,
    output logic            irq_ff
);
    import pimoc_pkg::*;

    typedef struct packed {
        logic irq;
    } pimoc_gate_s;

    localparam logic [3:0] IMPL = {(PORT_NUM == PORT_ANEG), HAS_PHY, HAS_PHY, 1'b1};

    pimoc_gate_s st_ff;
    pimoc_gate_s nxt_st;
    logic [3:0]  hit;

    // ------------------------------------------------------------
    // per-source gating
    // ------------------------------------------------------------
    genvar i;
    for (i = 0; i < 4; i++) begin : g_src
        assign hit[i] = sts[i] & ~mask[i] & IMPL[i]; // [R1] [R2] [R3] [R4] [R5] [R6]
    end

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.irq = |hit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign irq_ff = st_ff.irq;
endmodule

/* File: rtl/pimoc_lb_path.sv */
// Purpose: steers egress and ingress byte streams for MAC loopback modes
// Assumes: one byte per cycle, both sides on aclk
// Notes:   single register stage, no elastic buffer
`timescale 1ns/1ps
module pimoc_lb_path (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       local_lb,
    input  wire logic                       remote_lb,
    input  wire logic [pimoc_pkg::LB_W-1:0] fab_tx_data,
    input  wire logic                       fab_tx_valid,
    input  wire logic [pimoc_pkg::LB_W-1:0] pin_rx_data,
    input  wire logic                       pin_rx_valid,
    output logic [pimoc_pkg::LB_W-1:0]      fab_rx_data,
    output logic                            fab_rx_valid,
    output logic [pimoc_pkg::LB_W-1:0]      pin_tx_data,
    output logic                            pin_tx_valid
);
    import pimoc_pkg::*;

    typedef struct packed {
        logic [LB_W-1:0] pin_tx_data;
        logic            pin_tx_valid;
        logic [LB_W-1:0] fab_rx_data;
        logic            fab_rx_valid;
    } pimoc_lb_s;

    pimoc_lb_s st_ff;
    pimoc_lb_s nxt_st;

    // ------------------------------------------------------------
    // steering
    // ------------------------------------------------------------
    // no rate matching: a clock mismatch on the far side corrupts long bursts
    always_comb begin
        nxt_st = '0;
        if (remote_lb) begin
            nxt_st.pin_tx_data  = pin_rx_data;  // [R8] [R9] [R10] [R11]
            nxt_st.pin_tx_valid = pin_rx_valid;
        end else if (!local_lb) begin
            nxt_st.pin_tx_data  = fab_tx_data;
            nxt_st.pin_tx_valid = fab_tx_valid;
        end
        if (local_lb) begin
            nxt_st.fab_rx_data  = fab_tx_data;  // [R7]
            nxt_st.fab_rx_valid = fab_tx_valid;
        end else if (!remote_lb) begin
            nxt_st.fab_rx_data  = pin_rx_data;
            nxt_st.fab_rx_valid = pin_rx_valid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_tx_data  = st_ff.pin_tx_data;
    assign pin_tx_valid = st_ff.pin_tx_valid;
    assign fab_rx_data  = st_ff.fab_rx_data;
    assign fab_rx_valid = st_ff.fab_rx_valid;
endmodule

/* File: rtl/pimoc_top.sv */
// Purpose: per-port interrupt enable mask and operation control, AXI4-Lite slave
// Assumes: event levels and byte streams synchronous to aclk
// Notes:   status bits 3:1 follow their sources, bit 0 is latched
//
// What this block does
// (R1) status reaches interrupt only when enabled
// (R2) mask bit 3 gates auto-negotiation done
// (R3) auto-negotiation mask acts on port 7 only
// (R4) mask 0 enables, 1 disables, reset 0
// (R5) bits 2,1 gate timestamp, PHY events
// (R6) bit 0 gates ACL on every port
// (R7) bit 7 returns egress frames to fabric
// (R8) bit 6 loops pin frames back out
// (R9) PHY port: line rx to line tx
// (R10) media port: tx inputs to rx outputs
// (R11) remote path has no elastic buffer
// (R12) software sends few short frames in loopback
// (R13) bit 2 marks tail-tagged host port
// (R14) software enables tail tagging on one port
// (R15) bits 1:0 pick two or four queues
// (R16) code 00 gives one plain queue
// (R17) toggling ACL enable clears ACL status
// (R18) status bits 3:0 mirror events before mask gating
// (R19) reserved bits read zero, ignore writes
// (R20) reserved queue code acts as one queue
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module pimoc_top #(
    parameter int PORT_NUM = 1,
    parameter bit HAS_PHY  = 1'b1
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [pimoc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [pimoc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [pimoc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [pimoc_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         aneg_done_sts,
    input  wire logic                         ptp_sts,
    input  wire logic                         phy_sts,
    input  wire logic                         acl_evt,
    output logic                              port_irq,
    output logic                              tail_tag_en,
    output logic [1:0]                        egress_queue_mode,
    input  wire logic [pimoc_pkg::LB_W-1:0]   fab_tx_data,
    input  wire logic                         fab_tx_valid,
    input  wire logic [pimoc_pkg::LB_W-1:0]   pin_rx_data,
    input  wire logic                         pin_rx_valid,
    output logic [pimoc_pkg::LB_W-1:0]        fab_rx_data,
    output logic                              fab_rx_valid,
    output logic [pimoc_pkg::LB_W-1:0]        pin_tx_data,
    output logic                              pin_tx_valid
);
    import pimoc_pkg::*;

    typedef struct packed {
        pimoc_wr_e         wst;
        logic              aw_got;
        logic              w_got;
        logic [7:0]        wr_idx;
        logic [7:0]        wbyte;
        logic              wstrb0;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic [3:0]        mask;
        logic              lb_local;
        logic              lb_remote;
        logic              tail;
        logic [1:0]        qsplit;
        logic [1:0]        q_eff;
        logic [3:0]        sts;
    } pimoc_top_s;

    localparam logic [3:0] IMPL = {(PORT_NUM == PORT_ANEG), HAS_PHY, HAS_PHY, 1'b1};

    pimoc_top_s st_ff;
    pimoc_top_s nxt_st;
    logic       wr_do;
    logic       wr_acl_clr;
    logic       exp_irq;

    // ------------------------------------------------------------
    // bus slave and register file
    // ------------------------------------------------------------
    always_comb begin
        nxt_st     = st_ff;
        wr_do      = 1'b0;
        wr_acl_clr = 1'b0;

        // write address and data, taken in either order
        if (st_ff.wst != WR_RESP) begin
            if (s_axi_awvalid && st_ff.awready) begin
                nxt_st.aw_got = 1'b1;
                nxt_st.wr_idx = s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && st_ff.wready) begin
                nxt_st.w_got  = 1'b1;
                nxt_st.wbyte  = s_axi_wdata[7:0];
                nxt_st.wstrb0 = s_axi_wstrb[0];
            end
        end

        case (st_ff.wst)
            WR_IDLE, WR_PART: begin
                if (nxt_st.aw_got && nxt_st.w_got) begin
                    wr_do         = 1'b1;
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got  = 1'b0;
                    nxt_st.bvalid = 1'b1;
                    nxt_st.bresp  = RESP_OKAY;
                    nxt_st.wst    = WR_RESP;
                end else if (nxt_st.aw_got || nxt_st.w_got) begin
                    nxt_st.wst = WR_PART;
                end else begin
                    nxt_st.wst = WR_IDLE;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_st.bvalid = 1'b0;
                    nxt_st.wst    = WR_IDLE;
                end
            end
            default: begin
                nxt_st.wst = WR_IDLE;
            end
        endcase

        // register update; reserved bits are simply not stored
        if (wr_do) begin
            if (nxt_st.wr_idx == IDX_IRQ_MASK) begin
                if (nxt_st.wstrb0) begin
                    nxt_st.mask = nxt_st.wbyte[3:0];                      // [R4] [R19]
                    wr_acl_clr  = nxt_st.wbyte[MSK_ACL] != st_ff.mask[MSK_ACL]; // [R17]
                end
            end else if (nxt_st.wr_idx == IDX_OP_CTL) begin
                if (nxt_st.wstrb0) begin
                    nxt_st.lb_local  = nxt_st.wbyte[OPC_LOCAL_LB];         // [R7]
                    nxt_st.lb_remote = nxt_st.wbyte[OPC_REMOTE_LB];        // [R8]
                    nxt_st.tail      = nxt_st.wbyte[OPC_TAIL];             // [R13]
                    nxt_st.qsplit    = nxt_st.wbyte[OPC_QS_HI:OPC_QS_LO];  // [R15] [R19]
                end
            end else if (nxt_st.wr_idx != IDX_IRQ_STATUS) begin
                nxt_st.bresp = RESP_SLVERR;
            end
        end

        // read channel, one outstanding
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rresp   = RESP_OKAY;
            if (s_axi_araddr[ADDR_W-1:2] == IDX_IRQ_STATUS) begin
                nxt_st.rdata = {28'h000_0000, st_ff.sts};                // [R18]
            end else if (s_axi_araddr[ADDR_W-1:2] == IDX_IRQ_MASK) begin
                nxt_st.rdata = {28'h000_0000, st_ff.mask};               // [R19]
            end else if (s_axi_araddr[ADDR_W-1:2] == IDX_OP_CTL) begin
                nxt_st.rdata = {24'h00_0000, st_ff.lb_local, st_ff.lb_remote,
                                3'h0, st_ff.tail, st_ff.qsplit};         // [R19]
            end else begin
                nxt_st.rdata = 32'h0000_0000;
                nxt_st.rresp = RESP_SLVERR;
            end
        end

        nxt_st.awready = (nxt_st.wst != WR_RESP) && !nxt_st.aw_got;
        nxt_st.wready  = (nxt_st.wst != WR_RESP) && !nxt_st.w_got;

        // ------------------------------------------------------------
        // status capture
        // ------------------------------------------------------------
        // a new ACL event in the clearing cycle wins over the toggle
        nxt_st.sts[3:1]     = {aneg_done_sts, ptp_sts, phy_sts};         // [R18]
        nxt_st.sts[MSK_ACL] = acl_evt | (st_ff.sts[MSK_ACL] & ~wr_acl_clr); // [R17] [R18]

        // reserved split code falls back to a single queue
        nxt_st.q_eff = (st_ff.qsplit == QS_RSVD) ? QS_ONE : st_ff.qsplit; // [R15] [R16] [R20]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff         <= '0;
            st_ff.wst     <= WR_IDLE;
            st_ff.awready <= 1'b1;
            st_ff.wready  <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.mask    <= MASK_RST;
            st_ff.qsplit  <= QS_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    pimoc_irq_gate #(
        .PORT_NUM (PORT_NUM),
        .HAS_PHY  (HAS_PHY)
    ) u_gate (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sts     (st_ff.sts),
        .mask    (st_ff.mask),
        .irq_ff  (port_irq)
    );

    pimoc_lb_path u_lb (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .local_lb     (st_ff.lb_local),
        .remote_lb    (st_ff.lb_remote),
        .fab_tx_data  (fab_tx_data),
        .fab_tx_valid (fab_tx_valid),
        .pin_rx_data  (pin_rx_data),
        .pin_rx_valid (pin_rx_valid),
        .fab_rx_data  (fab_rx_data),
        .fab_rx_valid (fab_rx_valid),
        .pin_tx_data  (pin_tx_data),
        .pin_tx_valid (pin_tx_valid)
    );

    assign s_axi_awready     = st_ff.awready;
    assign s_axi_wready      = st_ff.wready;
    assign s_axi_bvalid      = st_ff.bvalid;
    assign s_axi_bresp       = st_ff.bresp;
    assign s_axi_arready     = st_ff.arready;
    assign s_axi_rvalid      = st_ff.rvalid;
    assign s_axi_rdata       = st_ff.rdata;
    assign s_axi_rresp       = st_ff.rresp;
    assign tail_tag_en       = st_ff.tail;   // [R13]
    assign egress_queue_mode = st_ff.q_eff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    assign exp_irq = |(st_ff.sts & ~st_ff.mask & IMPL);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_tail_wr;
        wr_do && nxt_st.wr_idx == IDX_OP_CTL && nxt_st.wstrb0 && nxt_st.wbyte[OPC_TAIL];
    endsequence
    sequence s_rd_mask;
        s_axi_arvalid && st_ff.arready && s_axi_araddr[ADDR_W-1:2] == IDX_IRQ_MASK;
    endsequence
    sequence s_rd_answer;
        st_ff.rvalid && st_ff.rdata[31:4] == 28'h000_0000;
    endsequence

    AST_IRQ_GATE: assert property (1'b1 |=> port_irq == $past(exp_irq)) // [R1] [R4]
        else $error("interrupt does not follow enabled status");
    AST_ANEG_PORT7: assert property ( // [R2] [R3]
        (st_ff.sts == 4'h8 && !st_ff.mask[MSK_ANEG]) |=> port_irq == (PORT_NUM == PORT_ANEG))
        else $error("auto-negotiation interrupt on wrong port");
    AST_PHY_ONLY: assert property ( // [R5]
        (st_ff.sts[3] == 1'b0 && st_ff.sts[0] == 1'b0
         && |(st_ff.sts[2:1] & ~st_ff.mask[2:1])) |=> port_irq == HAS_PHY)
        else $error("timestamp or PHY interrupt on port without PHY");
    AST_ACL_ANY: assert property ((st_ff.sts[MSK_ACL] && !st_ff.mask[MSK_ACL]) |=> port_irq) // [R6]
        else $error("enabled ACL status gave no interrupt");
    AST_ALL_MASKED: assert property ((st_ff.mask == 4'hf) [*2] |=> !port_irq) // [R4]
        else $error("interrupt with all sources disabled");
    AST_LOCAL_LB: assert property ( // [R7]
        (st_ff.lb_local && !st_ff.lb_remote && fab_tx_valid)
        |=> fab_rx_valid && fab_rx_data == $past(fab_tx_data) && !pin_tx_valid)
        else $error("local loopback did not return egress byte");
    AST_REMOTE_LB: assert property ( // [R8] [R9] [R10] [R11]
        (st_ff.lb_remote && pin_rx_valid)
        |=> pin_tx_valid && pin_tx_data == $past(pin_rx_data))
        else $error("remote loopback byte not sent one cycle later");
    AST_REMOTE_ISOLATE: assert property ((st_ff.lb_remote && !st_ff.lb_local) |=> !fab_rx_valid) // [R8]
        else $error("remote loopback leaked into fabric");
    AST_TAIL_WRITE: assert property (s_tail_wr |=> tail_tag_en) // [R13]
        else $error("tail tag enable not set by write");
    AST_QUEUE_MAP: assert property ( // [R15] [R16]
        (st_ff.qsplit != QS_RSVD) |=> egress_queue_mode == $past(st_ff.qsplit))
        else $error("queue mode does not follow split code");
    AST_QUEUE_RSVD: assert property ((st_ff.qsplit == QS_RSVD) |=> egress_queue_mode == QS_ONE) // [R20]
        else $error("reserved split code not treated as one queue");
    AST_ACL_CLEAR: assert property ((wr_acl_clr && !acl_evt) |=> !st_ff.sts[MSK_ACL]) // [R17]
        else $error("ACL status not cleared by enable toggle");
    AST_ACL_SET: assert property (acl_evt |=> st_ff.sts[MSK_ACL]) // [R18]
        else $error("ACL event lost");
    AST_RSVD_READ: assert property (s_rd_mask |=> s_rd_answer) // [R19]
        else $error("reserved mask bits read nonzero");
    AST_B_HOLD: assert property ((st_ff.bvalid && !s_axi_bready) |=> st_ff.bvalid)
        else $error("write response dropped before bready");

    // handshake timing the bench depends on
    sequence s_rd_take;
        s_axi_arvalid && st_ff.arready;
    endsequence

    AST_AR_ANSWER: assert property (
        s_rd_take
        |=> st_ff.rvalid && !st_ff.arready)
        else $error("read not answered next cycle");
    AST_R_HOLD: assert property (
        (st_ff.rvalid && !s_axi_rready)
        |=> st_ff.rvalid && $stable(st_ff.rdata))
        else $error("read data dropped before rready");
    AST_R_DONE: assert property (
        (st_ff.rvalid && s_axi_rready)
        |=> !st_ff.rvalid && st_ff.arready)
        else $error("read channel not freed");
    AST_WR_ANSWER: assert property (
        wr_do
        |=> st_ff.bvalid && !st_ff.awready && !st_ff.wready)
        else $error("write not answered next cycle");
    AST_OP_RSVD: assert property ( // [R19]
        (s_axi_arvalid && st_ff.arready && s_axi_araddr[ADDR_W-1:2] == IDX_OP_CTL)
        |=> st_ff.rdata[31:8] == 24'h00_0000 && st_ff.rdata[5:3] == 3'h0)
        else $error("reserved control bits read nonzero");
endmodule

/* File: testbench/test_port_irq_mask_and_op_control.sv */
// Purpose: self-checking bench for the port interrupt mask / operation control bank
// Assumes: port 7 with PHY so every mask source is implemented
// Notes:   all waits bounded; expectations worked out from the register map
`timescale 1ns/1ps
module test_port_irq_mask_and_op_control;
    import pimoc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, port_irq, tail_tag_en;
    logic        fab_tx_valid, pin_rx_valid, fab_rx_valid, pin_tx_valid;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, egress_queue_mode, r;
    logic [3:0]  src;
    logic [7:0]  fab_tx_data, pin_rx_data, fab_rx_data, pin_tx_data;
    logic [1:0]  qexp [4];
    int          n_fail, checked, i;

    pimoc_top #(.PORT_NUM(7), .HAS_PHY(1'b1)) pimoc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .aneg_done_sts(src[3]), .ptp_sts(src[2]), .phy_sts(src[1]),
        .acl_evt(src[0]), .port_irq(port_irq), .tail_tag_en(tail_tag_en),
        .egress_queue_mode(egress_queue_mode), .fab_tx_data(fab_tx_data), .fab_tx_valid(fab_tx_valid),
        .pin_rx_data(pin_rx_data), .pin_rx_valid(pin_rx_valid), .fab_rx_data(fab_rx_data),
        .fab_rx_valid(fab_rx_valid), .pin_tx_data(pin_tx_data), .pin_tx_valid(pin_tx_valid));

    // ------------------------------------------------------------
    // clock, reporting
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (n == 20) begin
            n_fail++;
            print_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n == 20) begin
            n_fail++;
            print_verdict();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic irq_sources();
        for (i = 1; i < 4; i++) begin
            wr(IDX_IRQ_MASK, 8'h0f ^ (8'h01 << i), r);
            @(posedge aclk);
            src <= 4'h1 << i;
            repeat (2) @(posedge aclk);
            #1;
            chk("irq_enabled", port_irq, 1'b1);
            rd(IDX_IRQ_STATUS, d, r);
            chk("status", d, 32'h0000_0001 << i);
            wr(IDX_IRQ_MASK, 8'h0f, r);
            repeat (2) @(posedge aclk);
            #1;
            chk("irq_masked", port_irq, 1'b0);
        end
        @(posedge aclk);
        src <= 4'h0;
    endtask

    task automatic acl_sticky();
        wr(IDX_IRQ_MASK, 8'h0e, r);
        @(posedge aclk);
        src <= 4'h1;
        @(posedge aclk);
        src <= 4'h0;
        repeat (2) @(posedge aclk);
        #1;
        chk("acl_irq", port_irq, 1'b1);
        wr(IDX_IRQ_MASK, 8'h0e, r);
        rd(IDX_IRQ_STATUS, d, r);
        chk("acl_held", d, 32'h0000_0001);
        wr(IDX_IRQ_MASK, 8'h0f, r);
        wr(IDX_IRQ_MASK, 8'h0e, r);
        repeat (2) @(posedge aclk);
        #1;
        chk("acl_cleared_irq", port_irq, 1'b0);
        rd(IDX_IRQ_STATUS, d, r);
        chk("acl_cleared", d, 32'h0000_0000);
    endtask

    task automatic loop_case(input logic [7:0] opc);
        logic [7:0] ft, pr;
        ft = opc ^ 8'h5a;
        pr = opc ^ 8'ha5;
        wr(IDX_OP_CTL, opc, r);
        @(posedge aclk);
        {fab_tx_data, pin_rx_data, fab_tx_valid, pin_rx_valid} <= {ft, pr, 2'b11}; // short burst
        @(posedge aclk);
        #1;
        chk("fab_rx_valid", fab_rx_valid, !(opc[6] && !opc[7]));
        chk("pin_tx_valid", pin_tx_valid, !(opc[7] && !opc[6]));
        if (!opc[6] || opc[7]) chk("fab_rx_data", fab_rx_data, opc[7] ? ft : pr);
        if (!opc[7] || opc[6]) chk("pin_tx_data", pin_tx_data, opc[6] ? pr : ft);
        @(posedge aclk);
        {fab_tx_valid, pin_rx_valid} <= 2'b00;
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, src} = '0;
        {awaddr, araddr, wdata} = '0;
        {fab_tx_data, pin_rx_data} = '0;
        fab_tx_valid = 1'b0;
        pin_rx_valid = 1'b0;
        qexp = '{QS_ONE, QS_TWO, QS_FOUR, QS_ONE};
        n_fail = 0;
        checked = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_IRQ_MASK, d, r);
        chk("mask_reset", d, 32'h0000_0000);
        rd(IDX_OP_CTL, d, r);
        chk("opctl_reset", d, 32'h0000_0000);
        chk("qmode_reset", egress_queue_mode, QS_ONE);
        wr(IDX_IRQ_MASK, 8'hff, r);
        rd(IDX_IRQ_MASK, d, r);
        chk("mask_rsvd", d, 32'h0000_000f);
        irq_sources();
        acl_sticky();
        for (int k = 0; k < 4; k++) begin
            wr(IDX_OP_CTL, 8'h04 | 8'(k), r);
            @(posedge aclk);
            #1;
            chk("qmode", egress_queue_mode, qexp[k]);
            chk("tail_tag", tail_tag_en, 1'b1);
            rd(IDX_OP_CTL, d, r);
            chk("opctl", d, 32'h0000_0004 | k);
        end
        wr(IDX_OP_CTL, 8'hff, r);
        rd(IDX_OP_CTL, d, r);
        chk("opctl_rsvd", d, 32'h0000_00c7);
        loop_case(8'h00);
        loop_case(8'h80);
        loop_case(8'h40);
        loop_case(8'hc0);
        wr(8'h30, 8'h01, r);
        chk("unmapped_wr", r, RESP_SLVERR);
        rd(8'h30, d, r);
        chk("unmapped_rd", d, 32'h0000_0000);
        chk("unmapped_rresp", r, RESP_SLVERR);
        wr(IDX_IRQ_STATUS, 8'hff, r);
        rd(IDX_IRQ_STATUS, d, r);
        chk("status_ro", d, 32'h0000_0000);
        chk("status_rresp", r, RESP_OKAY);
        print_verdict();
    end
endmodule
